/* inc/rcecp_cfg.svh */
`ifndef RCECP_CFG_SVH
`define RCECP_CFG_SVH

// Register byte offsets
`define RCECP_OFF_FLAGS   8'h00
`define RCECP_OFF_STATUS  8'h04
`define RCECP_OFF_MASK    8'h08
`define RCECP_OFF_OSC     8'h0C

// Cause flag bit positions
`define RCECP_B_PIN   0
`define RCECP_B_PWR   1
`define RCECP_B_CLK   2
`define RCECP_B_WDT   3
`define RCECP_B_SW    4
`define RCECP_B_CMP   5
`define RCECP_B_MEM   6

// Interrupt status bit positions
`define RCECP_I_RST   0
`define RCECP_I_CFG   1

// Oscillator control fields
`define RCECP_OSC_MODE_LSB  0
`define RCECP_OSC_FREQ_LSB  4

// Reset values
`define RCECP_FLAGS_RST   8'h02
`define RCECP_ZERO8       8'h00
`define RCECP_ZERO32      32'h0000_0000

// Reset pulse timing
`define RCECP_RST_TIME_NS 160
`define RCECP_CLK_NS      10
`define RCECP_RST_CYCLES  ((`RCECP_RST_TIME_NS + `RCECP_CLK_NS - 1) / `RCECP_CLK_NS)
`define RCECP_CNT_W       8

`endif

/* inc/rcecp_pkg.sv */
`default_nettype none
package rcecp_pkg;

  typedef enum logic [2:0] {
    RCECP_OSC_OFF     = 3'b000,
    RCECP_OSC_CRYSTAL = 3'b001,
    RCECP_OSC_CAP     = 3'b010,
    RCECP_OSC_RC      = 3'b011,
    RCECP_OSC_CMOS    = 3'b100
  } rcecp_osc_mode_t;

  typedef enum logic {
    RCECP_RST_IDLE = 1'b0,
    RCECP_RST_HOLD = 1'b1
  } rcecp_rst_state_t;

  typedef struct packed {
    rcecp_rst_state_t rstState;
    logic [7:0]       pulseCnt;
    logic [7:0]       flags;
    logic             clockLossEn;
    logic             vddEn;
    logic             compEn;
    rcecp_osc_mode_t  oscMode;
    logic [2:0]       freqCtl;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             sysResetOut;
    logic             irq;
  } rcecp_top_state_t;

  typedef struct packed {
    logic external_clock_input;
    logic claimed;
    logic misconfig;
  } rcecp_pin_state_t;

endpackage
`default_nettype wire

/* inc/rcecp_pin_if.sv */
`default_nettype none
interface rcecp_pin_if;
  import rcecp_pkg::*;
  rcecp_osc_mode_t oscMode;
  logic            skip3;
  logic            analog3;
  logic            pinIn;
  logic            external_clock_input;
  logic            claimed;
  logic            misconfig;

  modport ctrl (output oscMode, output skip3, output analog3, output pinIn,
                input external_clock_input, input claimed, input misconfig);
  modport pin  (input oscMode, input skip3, input analog3, input pinIn,
                output external_clock_input, output claimed, output misconfig);
endinterface
`default_nettype wire

/* hw/rcecp_osc_pin.sv */
`include "rcecp_cfg.svh"
`default_nettype none
module rcecp_osc_pin
  import rcecp_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   reset_n,
  input  wire logic   ce,
  rcecp_pin_if.pin    pif
);

  rcecp_pin_state_t st;
  rcecp_pin_state_t next_st;
  logic             takesPin;
  logic             wantAnalog;

  always_comb begin
    next_st    = st;
    takesPin   = (pif.oscMode == RCECP_OSC_CAP) || (pif.oscMode == RCECP_OSC_RC) ||
                 (pif.oscMode == RCECP_OSC_CMOS);
    wantAnalog = (pif.oscMode != RCECP_OSC_CMOS);
    next_st.claimed   = takesPin;
    next_st.external_clock_input    = takesPin && pif.pinIn;
    // Pin must be skipped and in the matching input mode
    next_st.misconfig = takesPin && (!pif.skip3 || (pif.analog3 != wantAnalog));
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pif.external_clock_input    = st.external_clock_input;
  assign pif.claimed   = st.claimed;
  assign pif.misconfig = st.misconfig;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_pin_follows: assert property (
    ce && pif.oscMode == RCECP_OSC_CMOS |=> pif.claimed && (pif.external_clock_input == $past(pif.pinIn)))
    else $error("external clock input does not follow the pin");

endmodule
`default_nettype wire

/* hw/rcecp_top.sv */
`include "rcecp_cfg.svh"
`default_nettype none
module rcecp_top
  import rcecp_pkg::*;
#(
  parameter int RST_CYCLES = `RCECP_RST_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supplyLow,
  input  wire logic        extPinReset,
  input  wire logic        clockMissing,
  input  wire logic        watchdogOverflow,
  input  wire logic        comp0Out,
  input  wire logic        memError,
  input  wire logic        p0Skip3,
  input  wire logic        p0Analog3,
  input  wire logic        port0Bit3Pin,
  output logic             sysResetOut,
  output logic             irq,
  output logic             extClkOut,
  output logic             pinClaimed
);

  rcecp_top_state_t st;
  rcecp_top_state_t next_st;
  rcecp_pin_if      pif ();

  logic       busAccess;
  logic       busCommit;
  logic       wrFlags;
  logic [7:0] causeVec;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, `RCECP_OFF_FLAGS) || hit(addr, `RCECP_OFF_STATUS) ||
             hit(addr, `RCECP_OFF_MASK) || hit(addr, `RCECP_OFF_OSC);
  endfunction

  // Keeps the highest-priority cause only
  function automatic logic [7:0] pickCause(input logic [7:0] c);
    pickCause = `RCECP_ZERO8;
    if (c[`RCECP_B_PWR]) begin
      pickCause[`RCECP_B_PWR] = 1'b1;
    end else if (c[`RCECP_B_PIN]) begin
      pickCause[`RCECP_B_PIN] = 1'b1;
    end else if (c[`RCECP_B_CLK]) begin
      pickCause[`RCECP_B_CLK] = 1'b1;
    end else if (c[`RCECP_B_WDT]) begin
      pickCause[`RCECP_B_WDT] = 1'b1;
    end else if (c[`RCECP_B_CMP]) begin
      pickCause[`RCECP_B_CMP] = 1'b1;
    end else if (c[`RCECP_B_SW]) begin
      pickCause[`RCECP_B_SW] = 1'b1;
    end else if (c[`RCECP_B_MEM]) begin
      pickCause[`RCECP_B_MEM] = 1'b1;
    end
  endfunction

  assign pif.oscMode = st.oscMode;
  assign pif.skip3   = p0Skip3;
  assign pif.analog3 = p0Analog3;
  assign pif.pinIn   = port0Bit3Pin;

  rcecp_osc_pin u_osc_pin (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .pif      (pif.pin)
  );

  always_comb begin
    next_st   = st;
    busAccess = psel && penable && !st.pready;
    busCommit = psel && penable && st.pready;
    wrFlags   = busCommit && pwrite && hit(paddr, `RCECP_OFF_FLAGS);
    causeVec  = `RCECP_ZERO8;

    // APB: answer one cycle into the access phase
    next_st.pready = busAccess;
    if (busAccess) begin
      next_st.pslverr = !mapped(paddr);
      next_st.prdata  = `RCECP_ZERO32;
      case (paddr)
        `RCECP_OFF_FLAGS:  next_st.prdata[7:0] = st.flags;
        `RCECP_OFF_STATUS: next_st.prdata[1:0] = st.status;
        `RCECP_OFF_MASK:   next_st.prdata[1:0] = st.mask;
        `RCECP_OFF_OSC: begin
          next_st.prdata[`RCECP_OSC_MODE_LSB +: 3] = st.oscMode;
          next_st.prdata[`RCECP_OSC_FREQ_LSB +: 3] = st.freqCtl;
        end
        default: next_st.prdata = `RCECP_ZERO32;
      endcase
    end

    // Register writes
    if (busCommit && pwrite) begin
      case (paddr)
        `RCECP_OFF_FLAGS: begin
          next_st.clockLossEn = pwdata[`RCECP_B_CLK];
          next_st.vddEn       = pwdata[`RCECP_B_PWR];
          next_st.compEn      = pwdata[`RCECP_B_CMP];
        end
        `RCECP_OFF_STATUS: next_st.status = st.status & ~pwdata[1:0];
        `RCECP_OFF_MASK:   next_st.mask   = pwdata[1:0];
        `RCECP_OFF_OSC: begin
          next_st.oscMode = rcecp_osc_mode_t'(pwdata[`RCECP_OSC_MODE_LSB +: 3]);
          next_st.freqCtl = pwdata[`RCECP_OSC_FREQ_LSB +: 3];
        end
        default: next_st.mask = st.mask;
      endcase
    end

    // Reset sources
    causeVec[`RCECP_B_PWR] = supplyLow && st.vddEn;
    causeVec[`RCECP_B_PIN] = extPinReset;
    causeVec[`RCECP_B_CLK] = clockMissing && st.clockLossEn;
    causeVec[`RCECP_B_WDT] = watchdogOverflow;
    causeVec[`RCECP_B_CMP] = !comp0Out && st.compEn;
    causeVec[`RCECP_B_SW]  = wrFlags && pwdata[`RCECP_B_SW];
    causeVec[`RCECP_B_MEM] = memError;

    case (st.rstState)
      RCECP_RST_IDLE: begin
        if (|causeVec) begin
          // One-hot capture; all other flags, power-on flag included, read zero
          next_st.flags       = pickCause(causeVec);
          next_st.rstState    = RCECP_RST_HOLD;
          next_st.pulseCnt    = 8'(RST_CYCLES - 1);
          next_st.sysResetOut = 1'b1;
          next_st.clockLossEn = 1'b0;
          next_st.compEn      = 1'b0;
        end
      end
      RCECP_RST_HOLD: begin
        if (st.pulseCnt == `RCECP_ZERO8) begin
          next_st.rstState    = RCECP_RST_IDLE;
          next_st.sysResetOut = 1'b0;
        end else begin
          next_st.pulseCnt = st.pulseCnt - 8'h01;
        end
      end
      default: next_st.rstState = RCECP_RST_IDLE;
    endcase

    // Sticky events win over a same-cycle clear
    if (st.rstState == RCECP_RST_IDLE && |causeVec) begin
      next_st.status[`RCECP_I_RST] = 1'b1;
    end
    if (pif.misconfig) begin
      next_st.status[`RCECP_I_CFG] = 1'b1;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st             <= '0;
      st.flags       <= `RCECP_FLAGS_RST;
      st.rstState    <= RCECP_RST_IDLE;
      st.oscMode     <= RCECP_OSC_OFF;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign sysResetOut = st.sysResetOut;
  assign irq         = st.irq;
  assign extClkOut   = pif.external_clock_input;
  assign pinClaimed  = pif.claimed;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_clk_loss_reset: assert property (
    ce && st.rstState == RCECP_RST_IDLE && st.clockLossEn && clockMissing
    |=> sysResetOut)
    else $error("clock loss did not raise a system reset");

  chk_clk_loss_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && st.clockLossEn && clockMissing &&
    !(supplyLow && st.vddEn) && !extPinReset
    |=> st.flags == 8'h04)
    else $error("clock loss flag not captured alone");

  chk_vdd_enable: assert property (
    ce && busCommit && pwrite && hit(paddr, `RCECP_OFF_FLAGS) && pwdata[`RCECP_B_PWR] &&
    st.rstState == RCECP_RST_IDLE |=> st.vddEn)
    else $error("supply monitor enable not taken");

  chk_power_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && supplyLow && st.vddEn
    |=> st.flags == 8'h02 && sysResetOut)
    else $error("power-on flag not set by monitor reset");

  chk_pin_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && extPinReset && !(supplyLow && st.vddEn)
    |=> st.flags == 8'h01)
    else $error("pin reset flag not captured");

  chk_comp_source: assert property (
    ce && st.rstState == RCECP_RST_IDLE && st.compEn && !comp0Out
    |=> sysResetOut ##0 $rose(st.rstState))
    else $error("comparator low did not raise a reset");

  chk_sw_force: assert property (
    ce && st.rstState == RCECP_RST_IDLE && wrFlags && pwdata[`RCECP_B_SW]
    |=> sysResetOut)
    else $error("software reset write ignored");

  chk_wdt_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && watchdogOverflow &&
    causeVec[2:0] == 3'h0 |=> st.flags == 8'h08)
    else $error("watchdog flag not captured");

  chk_read_flags: assert property (
    ce && busAccess && !pwrite && hit(paddr, `RCECP_OFF_FLAGS)
    |=> pready && prdata[7:0] == $past(st.flags))
    else $error("flag read did not return captured causes");

  chk_pulse_len: assert property (
    ce && $rose(sysResetOut) && RST_CYCLES == 16 |-> sysResetOut [*8])
    else $error("reset pulse too short");

  chk_flag_onehot: assert property (
    ce |-> $onehot(st.flags))
    else $error("not exactly one cause flag set");

  chk_flag_write: assert property (
    ce && wrFlags && !(st.rstState == RCECP_RST_IDLE && (|causeVec))
    |=> st.flags == $past(st.flags))
    else $error("flag register changed by a plain write");

  chk_hold_refuse: assert property (
    ce && st.rstState == RCECP_RST_HOLD |=> st.flags == $past(st.flags))
    else $error("cause captured while reset pulse runs");

  chk_sw_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && wrFlags && pwdata[`RCECP_B_SW] &&
    causeVec[3:0] == 4'h0 && !causeVec[`RCECP_B_CMP] |=> st.flags == 8'h10)
    else $error("software reset flag not captured");

  chk_cmp_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && causeVec[`RCECP_B_CMP] &&
    causeVec[3:0] == 4'h0 |=> st.flags == 8'h20)
    else $error("comparator reset flag not captured");

  chk_mem_flag: assert property (
    ce && st.rstState == RCECP_RST_IDLE && memError && causeVec[5:0] == 6'h00
    |=> st.flags == 8'h40)
    else $error("memory error flag not captured");

  chk_enables_drop: assert property (
    ce && st.rstState == RCECP_RST_IDLE && (|causeVec)
    |=> !st.clockLossEn && !st.compEn)
    else $error("detector or comparator enable kept over a reset");

  chk_pulse_end: assert property (
    ce && st.rstState == RCECP_RST_HOLD && st.pulseCnt == 8'h00
    |=> !sysResetOut && st.rstState == RCECP_RST_IDLE)
    else $error("reset pulse did not end on count zero");

  chk_apb_pulse: assert property (
    ce && pready |=> !pready)
    else $error("ready held longer than one cycle");

  chk_unmapped_err: assert property (
    ce && busAccess && !mapped(paddr) |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  chk_irq_level: assert property (
    ce |-> irq == |(st.status & st.mask))
    else $error("interrupt output does not follow status and mask");

endmodule
`default_nettype wire

/* test/rcecp_top_bench.sv */
`include "rcecp_cfg.svh"
`default_nettype none
module rcecp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rcecp_pkg::*;
  localparam int RST = 16;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysResetOut;
  logic        irq;
  logic        extClkOut;
  logic        pinClaimed;
  logic        ce = 1'b1;
  logic [6:0]  src = 7'h00;
  logic        skip = 1'b0;
  logic        analog = 1'b0;
  logic        pin = 1'b0;
  logic [33:0] expQ[$];
  logic [33:0] e;
  logic [31:0] seed = 32'hC572;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // Source vector bits follow the flag bit positions
  rcecp_top #(.RST_CYCLES(RST)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supplyLow(src[1]), .extPinReset(src[0]), .clockMissing(src[2]),
    .watchdogOverflow(src[3]), .comp0Out(~src[5]), .memError(src[6]),
    .p0Skip3(skip), .p0Analog3(analog), .port0Bit3Pin(pin),
    .sysResetOut(sysResetOut), .irq(irq), .extClkOut(extClkOut), .pinClaimed(pinClaimed)
  );

  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Result watcher: pops the oldest note at each completed transfer
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) begin
        chk(prdata, e[31:0]);
      end
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] x);
    expQ.push_back(x);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, {2'b00, 32'h0});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    xfer(1'b0, a, 32'h0, {1'b1, err, d});
  endtask

  // Counts the cycles of the issued system reset
  task automatic hold(input int exp);
    int n;
    int w;
    n = 0;
    w = 0;
    #1;
    while (sysResetOut !== 1'b1 && w < 3) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    while (sysResetOut === 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n, exp);
  endtask

  task automatic evt(input int i, input int exp, input logic [31:0] f);
    @(posedge core_clk);
    src[i] <= 1'b1;
    @(posedge core_clk);
    src[i] <= 1'b0;
    hold(exp);
    rd(`RCECP_OFF_FLAGS, f, 1'b0);
  endtask

  initial begin
    int m;
    logic v;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`RCECP_OFF_FLAGS, 32'h02, 1'b0);
    rd(`RCECP_OFF_STATUS, 32'h00, 1'b0);
    rd(`RCECP_OFF_MASK, 32'h00, 1'b0);
    rd(8'h10, 32'h00, 1'b1);
    wr(`RCECP_OFF_FLAGS, 32'h04);
    rd(`RCECP_OFF_FLAGS, 32'h02, 1'b0);
    evt(2, RST, 32'h04);
    evt(2, 0, 32'h04);
    evt(0, RST, 32'h01);
    wr(`RCECP_OFF_FLAGS, 32'h01);
    rd(`RCECP_OFF_FLAGS, 32'h01, 1'b0);
    evt(3, RST, 32'h08);
    evt(5, 0, 32'h08);
    wr(`RCECP_OFF_FLAGS, 32'h20);
    evt(5, RST, 32'h20);
    evt(6, RST, 32'h40);
    wr(`RCECP_OFF_FLAGS, 32'h10);
    hold(RST);
    rd(`RCECP_OFF_FLAGS, 32'h10, 1'b0);
    evt(1, 0, 32'h10);
    wr(`RCECP_OFF_FLAGS, 32'h02);
    rd(`RCECP_OFF_FLAGS, 32'h10, 1'b0);
    evt(1, RST, 32'h02);
    chk(irq, 1'b0);
    rd(`RCECP_OFF_STATUS, 32'h01, 1'b0);
    wr(`RCECP_OFF_MASK, 32'h01);
    @(posedge core_clk);
    #1;
    chk(irq, 1'b1);
    wr(`RCECP_OFF_STATUS, 32'h01);
    @(posedge core_clk);
    #1;
    chk(irq, 1'b0);
    @(posedge core_clk);
    ce <= 1'b0;
    src[0] <= 1'b1;
    @(posedge core_clk);
    src[0] <= 1'b0;
    @(posedge core_clk);
    ce <= 1'b1;
    #1;
    chk(sysResetOut, 1'b0);
    rd(`RCECP_OFF_STATUS, 32'h00, 1'b0);
    @(posedge core_clk);
    skip <= 1'b1;
    for (m = 0; m < 5; m++) begin
      wr(`RCECP_OFF_OSC, 32'h0);
      analog <= (m != 4);
      wr(`RCECP_OFF_OSC, 32'(m * 17));
      rd(`RCECP_OFF_OSC, 32'(m * 17), 1'b0);
      repeat (4) begin
        @(posedge core_clk);
        v = seed[0];
        seed = xs(seed);
        pin <= v;
        @(posedge core_clk);
        #1;
        chk(pinClaimed, 32'(m >= 2));
        chk(extClkOut, (m >= 2) ? v : 1'b0);
      end
    end
    rd(`RCECP_OFF_STATUS, 32'h00, 1'b0);
    @(posedge core_clk);
    analog <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`RCECP_OFF_STATUS, 32'h02, 1'b0);
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
